// [rtl/pdhlic_regs.sv]
// Purpose: control and status bank for level-3 and tributary line interface units
// Assumes: single clock, synchronous status inputs, byte register port
// Notes:   read data stand one cycle after the read strobe, zero after other enabled cycles
//          channels 0/1 share the nibble layout of channels 2/3 one byte lower
//          status inputs are taken as already synchronous; no resampling here
`timescale 1ns/1ps
`default_nettype none
module pdhlic_regs
	import pdhlic_pkg::*;
#(
	parameter int unsigned NUM_L3   = L3_CHANNELS,
	parameter int unsigned NUM_TRIB = TRIB_CHANNELS
) (
	// clock, reset and freeze
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	// plain register port
	input  wire logic [REG_ADDR_W-1:0] reg_addr,
	input  wire logic [REG_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [REG_DATA_W-1:0] reg_rdata,
	// LIU status pins
	input  wire logic [NUM_L3-1:0]     level3_line_alarm,
	input  wire logic                  liu_serial_readback,
	// level-3 LIU control pins
	output logic      [NUM_L3-1:0]     level3_short_cable_buildout,
	output logic      [NUM_L3-1:0]     level3_remote_loop,
	output logic      [NUM_L3-1:0]     level3_loop_sel_a,
	output logic      [NUM_L3-1:0]     level3_loop_sel_b,
	output logic                       line_decoder_bypass,
	output logic                       level3_mode_sel_a,
	output logic                       level3_mode_sel_b,
	output logic      [NUM_L3-1:0]     level3_tx_data_on,
	output logic      [NUM_L3-1:0]     level3_tx_clk_on,
	// tributary LIU control pins
	output logic      [NUM_TRIB-1:0]   trib_data_on,
	output logic      [NUM_TRIB-1:0]   trib_pair_transmit,
	// serial programming and interrupt
	output logic                       liu_prog_serial_clock,
	output logic                       irq
);

	// write decode per register
	logic         wr_ctrl01;
	logic         wr_ctrl23;
	logic         wr_den_lo;
	logic         wr_den_hi;
	logic         wr_dir_lo;
	logic         wr_dir_hi;
	logic         wr_glob;
	logic         wr_txen;
	logic         wr_prog;
	logic         wr_mask;
	logic         rd_stat_clr;

	// stored control bytes
	pdhlic_byte_t ctrl01_q;
	pdhlic_byte_t ctrl23_q;
	pdhlic_byte_t den_lo_q;
	pdhlic_byte_t den_hi_q;
	pdhlic_byte_t dir_lo_q;
	pdhlic_byte_t dir_hi_q;
	pdhlic_byte_t glob_q;
	pdhlic_byte_t txen_q;
	pdhlic_byte_t prog_q;

	// status and interrupt
	pdhlic_byte_t                  l3_status;
	logic         [NUM_L3-1:0]     alarm_rise;
	logic         [NUM_L3-1:0]     alarm_fall;
	logic         [IRQ_EVENTS-1:0] irq_events;
	logic         [IRQ_EVENTS-1:0] irq_stat;
	logic         [IRQ_EVENTS-1:0] irq_mask;

	// read path
	pdhlic_byte_t rd_mux;
	pdhlic_byte_t rdata_d;
	pdhlic_byte_t rdata_q;

	// strobes qualified by the enable so a frozen block ignores the port
	// one decoder for every write; an unmapped address strobes nothing
	always_comb begin
		wr_ctrl01 = 1'b0;
		wr_ctrl23 = 1'b0;
		wr_den_lo = 1'b0;
		wr_den_hi = 1'b0;
		wr_dir_lo = 1'b0;
		wr_dir_hi = 1'b0;
		wr_glob   = 1'b0;
		wr_txen   = 1'b0;
		wr_prog   = 1'b0;
		wr_mask   = 1'b0;
		if (ce && reg_wr) begin
			unique case (reg_addr)
				OFS_L3_CTRL_CH0_CH1: wr_ctrl01 = 1'b1;
				OFS_L3_CTRL_CH2_CH3: wr_ctrl23 = 1'b1;
				OFS_TRIB_DEN_LO:     wr_den_lo = 1'b1;
				OFS_TRIB_DEN_HI:     wr_den_hi = 1'b1;
				OFS_TRIB_DIR_LO:     wr_dir_lo = 1'b1;
				OFS_TRIB_DIR_HI:     wr_dir_hi = 1'b1;
				OFS_L3_GLOBAL:       wr_glob   = 1'b1;
				OFS_L3_TX_ENABLE:    wr_txen   = 1'b1;
				OFS_LIU_PROG:        wr_prog   = 1'b1;
				OFS_IRQ_MASK:        wr_mask   = 1'b1;
				default:             wr_mask   = 1'b0;
			endcase
		end
	end

	// only a taken read of the event byte clears it
	assign rd_stat_clr = ce && reg_rd && (reg_addr == OFS_IRQ_STATUS);

	// line control, channels 0 and 1
	// same nibble layout as channels 2 and 3, one address lower
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl01_q <= RST_CTRL;
		end else if (wr_ctrl01) begin
			ctrl01_q <= reg_wdata;
		end
	end

	// line control, channel 3 high nibble, channel 2 low nibble
	// written whole; no bit of this byte is reserved
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl23_q <= RST_CTRL;
		end else if (wr_ctrl23) begin
			ctrl23_q <= reg_wdata;
		end
	end

	// tributary data enables, channels 7 to 0
	// a cleared bit keeps that data output quiet
	always_ff @(posedge clk) begin
		if (rst) begin
			den_lo_q <= RST_CTRL;
		end else if (wr_den_lo) begin
			den_lo_q <= reg_wdata;
		end
	end

	// tributary data enables, channels 15 to 8
	// bit 0 of this byte is channel 8
	always_ff @(posedge clk) begin
		if (rst) begin
			den_hi_q <= RST_CTRL;
		end else if (wr_den_hi) begin
			den_hi_q <= reg_wdata;
		end
	end

	// direction, reset to receive on every pair
	// a pair never drives the line until software asks for it
	always_ff @(posedge clk) begin
		if (rst) begin
			dir_lo_q <= RST_CTRL;
		end else if (wr_dir_lo) begin
			dir_lo_q <= reg_wdata;
		end
	end

	// direction, channels 15 to 8, also receive after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			dir_hi_q <= RST_CTRL;
		end else if (wr_dir_hi) begin
			dir_hi_q <= reg_wdata;
		end
	end

	// global mode; only the three live bits are stored
	// the upper five bits drive nothing, so storing them would waste flops
	always_ff @(posedge clk) begin
		if (rst) begin
			glob_q <= RST_CTRL;
		end else if (wr_glob) begin
			glob_q <= reg_wdata & GLOB_WR_MASK;
		end
	end

	// transmit data and clock enables
	// all eight bits live; odd bits data, even bits clock
	always_ff @(posedge clk) begin
		if (rst) begin
			txen_q <= RST_CTRL;
		end else if (wr_txen) begin
			txen_q <= reg_wdata;
		end
	end

	// serial programming clock; other bits of this byte are not held here
	// select, data and LIU reset pins are not part of this bank
	always_ff @(posedge clk) begin
		if (rst) begin
			prog_q <= RST_CTRL;
		end else if (wr_prog) begin
			prog_q <= reg_wdata & PROG_WR_MASK;
		end
	end

	// per-channel fan-out of line control and transmit enables
	// pure wiring from storage, so every pin moves one cycle after its write
	genvar ch;
	generate
		for (ch = 0; ch < NUM_L3; ch++) begin : g_l3
			localparam int unsigned NIB      = (ch % 2) * CH_FLD_W;
			localparam int unsigned BIT_BO   = NIB + FLD_BUILDOUT;
			localparam int unsigned BIT_RL   = NIB + FLD_REMOTE_LOOP;
			localparam int unsigned BIT_LA   = NIB + FLD_LOOP_A;
			localparam int unsigned BIT_LB   = NIB + FLD_LOOP_B;
			localparam int unsigned BIT_DATA = 2 * ch + TXEN_DATA_OFS;
			localparam int unsigned BIT_CLK  = 2 * ch + TXEN_CLK_OFS;
			logic [REG_DATA_W-1:0] src;
			// channels 0/1 live in the first byte, 2/3 in the second
			assign src = (ch < 2) ? ctrl01_q : ctrl23_q;
			// build-out only matters in T3; the LIU ignores it in E3
			assign level3_short_cable_buildout[ch] = src[BIT_BO];
			assign level3_remote_loop[ch] = src[BIT_RL];
			// LIU decodes A=B=0 as analog loopback; both passed through raw
			assign level3_loop_sel_a[ch] = src[BIT_LA];
			assign level3_loop_sel_b[ch] = src[BIT_LB];
			// data and clock enables interleave, data on the odd bit
			assign level3_tx_data_on[ch] = txen_q[BIT_DATA];
			assign level3_tx_clk_on[ch]  = txen_q[BIT_CLK];
		end
	endgenerate

	// tributary enables and directions, bit 0 of each high byte is channel 8
	// the high byte sits at the odd address and forms the upper half
	assign trib_data_on       = {den_hi_q, den_lo_q};
	assign trib_pair_transmit = {dir_hi_q, dir_lo_q};

	// one copy of the mode bits feeds all four LIUs
	// not forced equal: software writes both 1 for T3, both 0 for E3
	assign line_decoder_bypass = glob_q[GLOB_DEC_BYPASS];
	assign level3_mode_sel_a   = glob_q[GLOB_MODE_A];
	assign level3_mode_sel_b   = glob_q[GLOB_MODE_B];

	// bit-banged clock straight from storage, no retiming
	// its pace is set by software; writes must be slow enough for the LIU
	assign liu_prog_serial_clock = prog_q[PROG_SCK_BIT];

	// live status byte, unused bits zero
	// read live, so a read shows the pin levels of the strobe cycle
	always_comb begin
		l3_status = RD_UNMAPPED;
		l3_status[STAT_SERIAL_BIT] = liu_serial_readback;
		l3_status[STAT_ALARM_LSB +: NUM_L3] = level3_line_alarm;
	end

	// alarm edges become interrupt events
	// a pin already high at reset release counts as a rise
	pdhlic_edge #(
		.W(NUM_L3)
	) u_alarm_edge (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.level_in (level3_line_alarm),
		.rise     (alarm_rise),
		.fall     (alarm_fall)
	);

	// low nibble: alarm raised, high nibble: alarm cleared
	// both edges are events, so software hears of recovery as well
	assign irq_events = {alarm_fall, alarm_rise};

	// sticky status cleared by reading it, mask and level interrupt
	pdhlic_irq #(
		.W(IRQ_EVENTS)
	) u_irq (
		.clk         (clk),
		.rst         (rst),
		.ce          (ce),
		.event_in    (irq_events),
		.stat_rd_clr (rd_stat_clr),
		.mask_wr     (wr_mask),
		.mask_wdata  (reg_wdata),
		.stat_q      (irq_stat),
		.mask_q      (irq_mask),
		.irq         (irq)
	);

	// read select; anything unmapped answers zero rather than stalling
	// bits never stored read back zero because they are absent from storage
	always_comb begin
		rd_mux = RD_UNMAPPED;
		unique case (reg_addr)
			OFS_L3_CTRL_CH0_CH1: rd_mux = ctrl01_q;
			OFS_L3_CTRL_CH2_CH3: rd_mux = ctrl23_q;
			OFS_TRIB_DEN_LO:     rd_mux = den_lo_q;
			OFS_TRIB_DEN_HI:     rd_mux = den_hi_q;
			OFS_TRIB_DIR_LO:     rd_mux = dir_lo_q;
			OFS_TRIB_DIR_HI:     rd_mux = dir_hi_q;
			OFS_L3_STATUS:       rd_mux = l3_status;
			OFS_L3_GLOBAL:       rd_mux = glob_q;
			OFS_L3_TX_ENABLE:    rd_mux = txen_q;
			OFS_LIU_PROG:        rd_mux = prog_q;
			OFS_IRQ_STATUS:      rd_mux = irq_stat;
			OFS_IRQ_MASK:        rd_mux = irq_mask;
			default:             rd_mux = RD_UNMAPPED;
		endcase
	end

	// zero unless strobed, so the next enabled cycle without a read clears a stale byte
	assign rdata_d = reg_rd ? rd_mux : RD_UNMAPPED;

	// read data register, frozen with the clock enable
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= RD_UNMAPPED;
		end else if (ce) begin
			rdata_q <= rdata_d;
		end
	end

	// data output straight from the flop
	assign reg_rdata = rdata_q;

endmodule // pdhlic_regs
`default_nettype wire

// [shared/pdhlic_pkg.sv]
// Purpose: constants shared by the level-3 / tributary line interface control bank
// Assumes: byte-wide register port, 8-bit addresses
// Notes:   offsets are byte addresses on the plain register port
package pdhlic_pkg;

	// register port geometry
	localparam int unsigned REG_ADDR_W = 8;
	localparam int unsigned REG_DATA_W = 8;

	typedef logic [REG_DATA_W-1:0] pdhlic_byte_t;
	typedef logic [REG_ADDR_W-1:0] pdhlic_addr_t;

	// channel counts
	localparam int unsigned L3_CHANNELS   = 4;
	localparam int unsigned TRIB_CHANNELS = 16;
	localparam int unsigned IRQ_EVENTS    = 8;

	// register offsets
	localparam pdhlic_addr_t OFS_L3_CTRL_CH0_CH1 = 8'h2E;
	localparam pdhlic_addr_t OFS_L3_CTRL_CH2_CH3 = 8'h2F;
	localparam pdhlic_addr_t OFS_TRIB_DEN_LO     = 8'h3A;
	localparam pdhlic_addr_t OFS_TRIB_DEN_HI     = 8'h3B;
	localparam pdhlic_addr_t OFS_TRIB_DIR_LO     = 8'h3C;
	localparam pdhlic_addr_t OFS_TRIB_DIR_HI     = 8'h3D;
	localparam pdhlic_addr_t OFS_L3_STATUS       = 8'h48;
	localparam pdhlic_addr_t OFS_L3_GLOBAL       = 8'h49;
	localparam pdhlic_addr_t OFS_L3_TX_ENABLE    = 8'h4A;
	localparam pdhlic_addr_t OFS_LIU_PROG        = 8'h4C;
	localparam pdhlic_addr_t OFS_IRQ_STATUS      = 8'h80;
	localparam pdhlic_addr_t OFS_IRQ_MASK        = 8'h81;

	// per-channel nibble inside a line control register
	localparam int unsigned CH_FLD_W        = 4;
	localparam int unsigned FLD_BUILDOUT    = 3;
	localparam int unsigned FLD_REMOTE_LOOP = 2;
	localparam int unsigned FLD_LOOP_A      = 1;
	localparam int unsigned FLD_LOOP_B      = 0;

	// status register fields
	localparam int unsigned STAT_SERIAL_BIT = 4;
	localparam int unsigned STAT_ALARM_LSB  = 0;

	// global control fields
	localparam int unsigned GLOB_DEC_BYPASS = 2;
	localparam int unsigned GLOB_MODE_A     = 1;
	localparam int unsigned GLOB_MODE_B     = 0;
	localparam pdhlic_byte_t GLOB_WR_MASK   = 8'h07;

	// transmit enable: data on odd bit 2n+1, clock on even bit 2n
	localparam int unsigned TXEN_DATA_OFS = 1;
	localparam int unsigned TXEN_CLK_OFS  = 0;

	// serial programming clock bit
	localparam int unsigned PROG_SCK_BIT  = 6;
	localparam pdhlic_byte_t PROG_WR_MASK = 8'h40;

	// reset and idle values
	localparam pdhlic_byte_t RST_CTRL    = 8'h00;
	localparam pdhlic_byte_t RD_UNMAPPED = 8'h00;

endpackage

// [rtl/pdhlic_edge.sv]
// Purpose: per-bit rising and falling edge detection of status levels
// Assumes: inputs already synchronous to clk
// Notes:   history resets low, so a level high at release shows as a rise
`timescale 1ns/1ps
`default_nettype none
module pdhlic_edge #(
	parameter int unsigned W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] level_in,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] prev_q;

	// previous level, frozen with the clock enable
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_q <= '0;
		end else if (ce) begin
			prev_q <= level_in;
		end
	end

	// pulses only count while enabled, else a frozen history repeats them
	assign rise = ce ? (level_in & ~prev_q) : '0;
	assign fall = ce ? (~level_in & prev_q) : '0;
endmodule // pdhlic_edge
`default_nettype wire

// [rtl/pdhlic_irq.sv]
// Purpose: sticky event status, mask and level interrupt
// Assumes: status cleared as a whole by a read pulse
// Notes:   an event in the clearing cycle stays set
`timescale 1ns/1ps
`default_nettype none
module pdhlic_irq
	import pdhlic_pkg::*;
#(
	parameter int unsigned W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] event_in,
	input  wire logic         stat_rd_clr,
	input  wire logic         mask_wr,
	input  wire logic [W-1:0] mask_wdata,
	output logic      [W-1:0] stat_q,
	output logic      [W-1:0] mask_q,
	output logic              irq
);
	logic [W-1:0] stat_d;

	// set wins over the read clear
	always_comb begin
		stat_d = stat_rd_clr ? '0 : stat_q;
		stat_d = stat_d | event_in;
	end

	// sticky status bits
	always_ff @(posedge clk) begin
		if (rst) begin
			stat_q <= '0;
		end else if (ce) begin
			stat_q <= stat_d;
		end
	end

	// mask, same layout as status
	always_ff @(posedge clk) begin
		if (rst) begin
			mask_q <= '0;
		end else if (ce && mask_wr) begin
			mask_q <= mask_wdata;
		end
	end

	assign irq = |(stat_q & mask_q); // level, high while any enabled bit set
endmodule // pdhlic_irq
`default_nettype wire

// [dv/pdhlic_sva.sv]
// Purpose: port-level checks of the line interface control bank
// Assumes: one clock, synchronous active-high reset
// Notes:   control outputs are judged one cycle after the taking edge
`timescale 1ns/1ps
`default_nettype none
module pdhlic_sva
	import pdhlic_pkg::*;
#(
	parameter int unsigned NUM_L3   = 4,
	parameter int unsigned NUM_TRIB = 16
) (
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic                  ce,
	input wire logic [REG_ADDR_W-1:0] reg_addr,
	input wire logic [REG_DATA_W-1:0] reg_wdata,
	input wire logic                  reg_wr,
	input wire logic                  reg_rd,
	input wire logic [REG_DATA_W-1:0] reg_rdata,
	input wire logic [NUM_L3-1:0]     level3_line_alarm,
	input wire logic                  liu_serial_readback,
	input wire logic [NUM_L3-1:0]     level3_short_cable_buildout,
	input wire logic [NUM_L3-1:0]     level3_remote_loop,
	input wire logic [NUM_L3-1:0]     level3_loop_sel_a,
	input wire logic [NUM_L3-1:0]     level3_loop_sel_b,
	input wire logic                  line_decoder_bypass,
	input wire logic                  level3_mode_sel_a,
	input wire logic                  level3_mode_sel_b,
	input wire logic [NUM_L3-1:0]     level3_tx_data_on,
	input wire logic [NUM_L3-1:0]     level3_tx_clk_on,
	input wire logic [NUM_TRIB-1:0]   trib_data_on,
	input wire logic [NUM_TRIB-1:0]   trib_pair_transmit,
	input wire logic                  liu_prog_serial_clock
);
	logic       wr_en;
	logic [7:0] wd_q;
	// a write only counts with the clock enable up
	assign wr_en = ce && reg_wr;
	// write data of the previous cycle, compared against the outputs
	always_ff @(posedge clk) begin
		wd_q <= reg_wdata;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_ch23_line: assert property (
		wr_en && reg_addr == OFS_L3_CTRL_CH2_CH3 |=> {level3_short_cable_buildout[3:2],
		level3_remote_loop[3:2]} == {wd_q[7], wd_q[3], wd_q[6], wd_q[2]})
		else $error("channel 2/3 build-out or remote loop wrong");
	chk_loop_select: assert property (
		wr_en && reg_addr == OFS_L3_CTRL_CH2_CH3 |-> ##1 {level3_loop_sel_a[3:2],
		level3_loop_sel_b[3:2]} == {wd_q[5], wd_q[1], wd_q[4], wd_q[0]})
		else $error("channel 2/3 loop select wrong");
	chk_trib_en_lo: assert property (
		wr_en && reg_addr == OFS_TRIB_DEN_LO |=> trib_data_on[7:0] == wd_q)
		else $error("low tributary data enable wrong");
	chk_trib_dir_hi: assert property (
		wr_en && reg_addr == OFS_TRIB_DIR_HI |=> trib_pair_transmit[15:8] == wd_q)
		else $error("high tributary direction wrong");
	chk_global_mode: assert property (
		wr_en && reg_addr == OFS_L3_GLOBAL |=>
		{line_decoder_bypass, level3_mode_sel_a, level3_mode_sel_b} == wd_q[2:0])
		else $error("global level-3 control wrong");
	chk_txen_map: assert property (
		wr_en && reg_addr == OFS_L3_TX_ENABLE |=>
		level3_tx_data_on == {wd_q[7], wd_q[5], wd_q[3], wd_q[1]} &&
		level3_tx_clk_on == {wd_q[6], wd_q[4], wd_q[2], wd_q[0]})
		else $error("transmit enable mapping wrong");
	chk_prog_clock: assert property (
		wr_en && reg_addr == OFS_LIU_PROG |=> liu_prog_serial_clock == wd_q[6])
		else $error("serial programming clock wrong");
	chk_status_read: assert property (
		ce && reg_rd && reg_addr == OFS_L3_STATUS |=>
		reg_rdata == {3'h0, $past(liu_serial_readback), $past(level3_line_alarm)})
		else $error("status read data wrong");
	chk_rdata_idle: assert property (
		!(ce && reg_rd) |=> reg_rdata == RD_UNMAPPED)
		else $error("read data not idle");
	chk_ctrl_hold: assert property (
		!wr_en |=> $stable({level3_tx_data_on, level3_tx_clk_on, trib_data_on,
		trib_pair_transmit, level3_mode_sel_a, liu_prog_serial_clock}))
		else $error("control output moved without a write");
endmodule // pdhlic_sva
`default_nettype wire

// [dv/pdhlic_liu_model.sv]
// Purpose: behavioural line interface unit at the far side of the bank
// Assumes: its pins change only on the board clock
// Notes:   serial output toggles per programming clock rise, a stand-in pattern
`timescale 1ns/1ps
`default_nettype none
module pdhlic_liu_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [3:0] alarm_cmd,
	input  wire logic       prog_clk,
	output logic      [3:0] alarm_q,
	output logic            sdo_q
);
	logic prog_clk_q;
	// status pin follows the commanded line state one cycle late
	always_ff @(posedge clk) begin
		alarm_q <= rst ? 4'h0 : alarm_cmd;
	end
	// serial output advances only when software raises the clock bit
	always_ff @(posedge clk) begin
		prog_clk_q <= prog_clk;
		if (rst) begin
			sdo_q <= 1'b0;
		end else if (prog_clk && !prog_clk_q) begin
			sdo_q <= !sdo_q;
		end
	end
endmodule // pdhlic_liu_model
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: self-checking bench of the line interface control bank
// Assumes: 40 MHz clock, synchronous active-high reset
// Notes:   row table covers write and readback; awkward cases follow it
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import pdhlic_pkg::*;
();
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [3:0]  alarm_cmd = 4'h0;
	logic [7:0]  reg_rdata;
	logic [3:0]  alarm, bo, rl, sa, sb, txd, txc;
	logic        byp, ma, mb, sdo, pclk, irq;
	logic [15:0] den, dir;
	int          fail_count = 0;
	int          compares = 0;
	// address, write data, expected readback
	logic [23:0] rows [14] = '{24'h2FA5A5, 24'h2E5A5A, 24'h3A8181, 24'h3B7E7E,
		24'h3CC3C3, 24'h3D3C3C, 24'h48FF00, 24'h49FF07, 24'h490303, 24'h4A9696,
		24'h4CFF40, 24'h81FFFF, 24'h810000, 24'h55FF00};
	pdhlic_regs u_pdhlic_regs (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.level3_line_alarm(alarm), .liu_serial_readback(sdo),
		.level3_short_cable_buildout(bo), .level3_remote_loop(rl), .level3_loop_sel_a(sa),
		.level3_loop_sel_b(sb), .line_decoder_bypass(byp), .level3_mode_sel_a(ma),
		.level3_mode_sel_b(mb), .level3_tx_data_on(txd), .level3_tx_clk_on(txc),
		.trib_data_on(den), .trib_pair_transmit(dir), .liu_prog_serial_clock(pclk),
		.irq(irq));
	pdhlic_liu_model u_pdhlic_liu_model (.clk(clk), .rst(rst), .alarm_cmd(alarm_cmd),
		.prog_clk(pclk), .alarm_q(alarm), .sdo_q(sdo));
	// 25 ns period
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one bus cycle launched right after a rising edge
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask
	// the #1 lets the taking edge's updates land before sampling
	task automatic idle();
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
		idle();
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, 1'b1, a, 8'h00);
		idle();
		chk(reg_rdata, exp);
	endtask
	task automatic reset_outs();
		chk({bo, rl, sa, sb, byp, ma, mb, txd, txc, pclk, irq}, 32'h0);
		chk({den, dir}, 32'h0);
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// hang guard, far beyond the roughly 125 cycles the run needs
	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		test_done();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1;
		reset_outs();
		foreach (rows[i]) rd(rows[i][23:16], 8'h00);
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rows[i][7:0]);
		end
		chk({bo, rl, sa, sb}, 16'h9696);
		chk({den, dir}, 32'h7E813CC3);
		chk({byp, ma, mb, txd, txc, pclk}, 12'h72D);
		// clock enable low: a write must leave everything alone
		@(posedge clk) ce <= 1'b0;
		wr(OFS_L3_TX_ENABLE, 8'h00);
		chk({txd, txc}, 8'h96);
		@(posedge clk) ce <= 1'b1;
		wr(OFS_L3_TX_ENABLE, 8'h81);
		chk({txd, txc}, 8'h81);
		// write then read of the same place with no gap
		bus(1'b1, 1'b0, OFS_L3_CTRL_CH2_CH3, 8'h3C);
		rd(OFS_L3_CTRL_CH2_CH3, 8'h3C);
		// alarm rise is unmasked, its fall is masked
		wr(OFS_IRQ_MASK, 8'h02);
		@(posedge clk) alarm_cmd <= 4'h2;
		repeat (3) idle();
		chk(irq, 1'b1);
		rd(OFS_L3_STATUS, 8'h12);
		rd(OFS_IRQ_STATUS, 8'h02);
		chk(irq, 1'b0);
		@(posedge clk) alarm_cmd <= 4'h0;
		repeat (3) idle();
		chk(irq, 1'b0);
		rd(OFS_IRQ_STATUS, 8'h20);
		// one more programming clock rise flips the serial output back
		wr(OFS_LIU_PROG, 8'h00);
		wr(OFS_LIU_PROG, 8'h40);
		rd(OFS_L3_STATUS, 8'h00);
		// second reset in mid-run
		@(posedge clk) rst <= 1'b1;
		@(posedge clk);
		@(posedge clk) rst <= 1'b0;
		#1;
		reset_outs();
		rd(OFS_L3_GLOBAL, 8'h00);
		test_done();
	end
endmodule // tb_top
bind pdhlic_regs pdhlic_sva #(.NUM_L3(NUM_L3), .NUM_TRIB(NUM_TRIB)) u_pdhlic_sva (
	.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.level3_line_alarm(level3_line_alarm), .liu_serial_readback(liu_serial_readback),
	.level3_short_cable_buildout(level3_short_cable_buildout),
	.level3_remote_loop(level3_remote_loop), .level3_loop_sel_a(level3_loop_sel_a),
	.level3_loop_sel_b(level3_loop_sel_b), .line_decoder_bypass(line_decoder_bypass),
	.level3_mode_sel_a(level3_mode_sel_a), .level3_mode_sel_b(level3_mode_sel_b),
	.level3_tx_data_on(level3_tx_data_on), .level3_tx_clk_on(level3_tx_clk_on),
	.trib_data_on(trib_data_on), .trib_pair_transmit(trib_pair_transmit),
	.liu_prog_serial_clock(liu_prog_serial_clock));
`default_nettype wire
